// *** design/mft_ctrl_map.svh ***
// Register offsets, field positions and reset values of the timer control block.
// Assumes an 8-bit register port with byte offsets as below.
`ifndef MFT_CTRL_MAP_SVH
`define MFT_CTRL_MAP_SVH
// ==========================================================
// Offsets
`define MFT_OFS_COUNTER_CONTROL 8'hf8
`define MFT_OFS_OPERATING_MODE 8'hf9
`define MFT_OFS_INPUT_PIN_SETUP 8'hfa
`define MFT_OFS_PRESCALE_PRESET 8'hfb
`define MFT_OFS_OUTPUT_A_ACTIONS 8'hfc
`define MFT_OFS_OUTPUT_B_ACTIONS 8'hfd
`define MFT_OFS_COUNT_LO 8'hf0
`define MFT_OFS_COUNT_HI 8'hf1
`define MFT_OFS_CMP0_LO 8'hf2
`define MFT_OFS_CMP0_HI 8'hf3
`define MFT_OFS_CMP1_LO 8'hf4
`define MFT_OFS_CMP1_HI 8'hf5
`define MFT_OFS_REG0_LO 8'hf6
`define MFT_OFS_REG0_HI 8'hf7
`define MFT_OFS_REG1_LO 8'hee
`define MFT_OFS_REG1_HI 8'hef
// ==========================================================
// Counter control fields
`define MFT_CC_RUN 7
`define MFT_CC_CLR_CAP 6
`define MFT_CC_CLR_CMP 5
`define MFT_CC_CLEAR 4
`define MFT_CC_SWDIR 3
`define MFT_CC_DIRSTAT 2
`define MFT_CC_WRAPSTAT 1
`define MFT_CC_RUNSTAT 0
// Mode fields
`define MFT_OM_OEB 7
`define MFT_OM_OEA 6
`define MFT_OM_BIVALUE 5
`define MFT_OM_REG1 4
`define MFT_OM_REG0 3
`define MFT_OM_CLKCTL 2
`define MFT_OM_NORETRIG 1
`define MFT_OM_ONESHOT 0
// Action fields
`define MFT_OA_CMP0_HI 7
`define MFT_OA_CMP1_HI 5
`define MFT_OA_WRAP_HI 3
`define MFT_OA_EVENT 1
`define MFT_OA_PRESET 0
// Input setup fields
`define MFT_IP_FUNC_HI 7
`define MFT_IP_EDGE_A_HI 3
`define MFT_IP_EDGE_B_HI 1
// ==========================================================
// Reset values
`define MFT_RST_REG 8'h00
`define MFT_RST_PRESCALE 8'h00
`endif

// *** design/mft_ctrl_pkg.sv ***
// Types of the timer control block.
// Assumes the map header supplies offsets and fields.
package mft_ctrl_pkg;
  typedef enum logic [3:0] {
    MFT_LOAD0_MON1 = 4'h1,
    MFT_LOAD0_CAP1 = 4'h2,
    MFT_CAP0_MON1 = 4'h4,
    MFT_CAP_BOTH = 4'h8
  } mft_mode_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mft_bus_req_t;
  typedef struct packed {
    logic in_a;
    logic in_b;
    logic global_count_enable;
  } mft_pins_t;
  typedef struct packed {
    logic [7:0] counter_control;
    logic [7:0] operating_mode_select;
    logic [7:0] input_pin_setup;
    logic [7:0] prescale_preset;
    logic [7:0] output_a_actions;
    logic [7:0] output_b_actions;
    logic [15:0] cmp0;
    logic [15:0] cmp1;
    logic [15:0] reg0;
    logic [15:0] reg1;
    logic [15:0] count;
    logic [7:0] prescale;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic in_a;
    logic in_b;
    logic dir_up;
    logic wrap_seen;
    logic capture_wrap;
    logic out_a;
    logic out_b;
    logic chip_event;
    logic armed;
    logic [7:0] rdata;
  } mft_state_t;
endpackage

// *** design/mft_ctrl.sv ***
// Control, mode, input and output-action logic of a 16-bit up/down timer.
// Assumes a same-clock register master and asynchronous pins on in_a/in_b.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "mft_ctrl_map.svh"
module mft_ctrl #(
  parameter int INSTANCE = 0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire mft_ctrl_pkg::mft_bus_req_t bus,
  output logic [7:0] rdata,
  input wire mft_ctrl_pkg::mft_pins_t pins,
  output logic output_a,
  output logic output_b,
  output logic compare0_chip_event,
  output logic [15:0] count
);
  import mft_ctrl_pkg::*;

  // Only four timer instances exist
  if (INSTANCE < 0 || INSTANCE > 3)
  begin : g_bad_instance
    $error("INSTANCE must be 0 to 3");
  end

  // ==========================================================
  // Helpers
  // Edge selection: bit1 rising, bit0 falling
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                    input logic cur);
    edge_hit = (sel[1] & ~prev & cur) | (sel[0] & prev & ~cur);
  endfunction

  // Output action: 00 set, 01 toggle, 10 reset, 11 keep
  function automatic logic apply_action(input logic [1:0] act, input logic cur);
    case (act)
      2'b00: apply_action = 1'b1;
      2'b01: apply_action = ~cur;
      2'b10: apply_action = 1'b0;
      default: apply_action = cur;
    endcase
  endfunction

  // AND of codes of the events that fire; 11 when none fire
  function automatic logic [1:0] merge_actions(input logic [5:0] acts,
                                               input logic [2:0] hit);
    logic [1:0] m;
    m = 2'b11;
    for (int i = 0; i < 3; i++)
    begin
      if (hit[i])
      begin
        m = m & acts[2*i +: 2];
      end
    end
    merge_actions = m;
  endfunction

  function automatic logic [15:0] wr_half(input logic [15:0] v, input logic hi,
                                          input logic [7:0] d);
    wr_half = hi ? {d, v[7:0]} : {v[15:8], d};
  endfunction

  mft_state_t s_r;
  mft_state_t s_nxt;
  mft_mode_t mode;
  logic [3:0] func;
  logic ev_a;
  logic ev_b;
  logic gate_ok;
  logic trig;
  logic ext_clk;
  logic run;
  logic tick;
  logic pre_zero;
  logic cnt_en;
  logic cmp0_hit;
  logic cmp1_hit;
  logic wrap;
  logic cap0;
  logic cap1;
  logic clr;
  logic reload;
  logic parallel;
  logic pin_dir;
  logic pin_dir_up;
  logic [2:0] hits;
  logic a_lvl;
  logic b_lvl;
  logic up;

  // ==========================================================
  // Mode decode
  always_comb
  begin
    // mode table; reg1 mode ignored under bivalue
    if (s_r.operating_mode_select[`MFT_OM_BIVALUE])
    begin
      mode = s_r.operating_mode_select[`MFT_OM_REG0] ? MFT_CAP_BOTH : MFT_LOAD0_MON1;
    end
    else
    begin
      case ({s_r.operating_mode_select[`MFT_OM_REG1], s_r.operating_mode_select[`MFT_OM_REG0]})
        2'b00: mode = MFT_LOAD0_MON1;
        2'b10: mode = MFT_LOAD0_CAP1;
        2'b01: mode = MFT_CAP0_MON1;
        default: mode = MFT_CAP_BOTH;
      endcase
    end
  end

  // ==========================================================
  // Input pins and counting conditions
  always_comb
  begin
    func = s_r.input_pin_setup[`MFT_IP_FUNC_HI -: 4];
    // parallel mode on odd instances only
    parallel = s_r.operating_mode_select[`MFT_OM_CLKCTL] && (INSTANCE % 2 == 1);
    // Level moves once the last two stages agree; edge taken there, once
    a_lvl = (s_r.sync_a[1] == s_r.sync_a[2]) ? s_r.sync_a[2] : s_r.in_a;
    b_lvl = (s_r.sync_b[1] == s_r.sync_b[2]) ? s_r.sync_b[2] : s_r.in_b;
    ev_a = edge_hit(s_r.input_pin_setup[`MFT_IP_EDGE_A_HI -: 2], s_r.in_a, a_lvl);
    ev_b = edge_hit(s_r.input_pin_setup[`MFT_IP_EDGE_B_HI -: 2], s_r.in_b, b_lvl);
    gate_ok = 1'b1;
    trig = 1'b0;
    ext_clk = 1'b0;
    pin_dir = 1'b0;
    pin_dir_up = 1'b0;
    case (func)
      4'h1: trig = ev_b;
      4'h2: gate_ok = s_r.in_a;
      4'h3:
      begin
        gate_ok = s_r.in_a;
        trig = ev_b;
      end
      4'h4: ext_clk = ev_b;
      4'h5: trig = ev_a;
      4'h6:
      begin
        gate_ok = s_r.in_a;
        ext_clk = ev_b;
      end
      4'h7: trig = ev_a | ev_b;
      4'h8:
      begin
        ext_clk = ev_a | ev_b;
        pin_dir = 1'b1;
        // Direction holds between pin events
        pin_dir_up = ev_a | (s_r.dir_up & ~ev_b);
      end
      4'h9:
      begin
        ext_clk = ev_b;
        pin_dir = 1'b1;
        pin_dir_up = s_r.in_a;
      end
      4'ha:
      begin
        trig = ev_a | ev_b;
        pin_dir = 1'b1;
        pin_dir_up = ev_a | (s_r.dir_up & ~ev_b);
      end
      4'hb:
      begin
        pin_dir = 1'b1;
        pin_dir_up = s_r.in_a;
      end
      4'hc:
      begin
        // Quadrature: A edge counts, B level fixes direction
        ext_clk = ev_a;
        pin_dir = 1'b1;
        pin_dir_up = ~s_r.in_b;
      end
      4'hd:
      begin
        trig = ev_a;
        ext_clk = ev_b;
      end
      4'he:
      begin
        ext_clk = ev_a;
        trig = ev_b;
      end
      4'hf:
      begin
        trig = ev_a;
        gate_ok = s_r.in_b;
      end
      default: trig = 1'b0;
    endcase
    // Parallel mode: prescaler clocked internally, pins keep other roles
    if (parallel)
    begin
      ext_clk = 1'b0;
    end
    // pins fix direction, else software bit
    up = pin_dir ? pin_dir_up : s_r.counter_control[`MFT_CC_SWDIR];
    // local and global enables both needed
    run = s_r.counter_control[`MFT_CC_RUN] & pins.global_count_enable & gate_ok
          & ~s_r.armed;
    tick = (func == 4'h4 || func == 4'h6 || func == 4'h8 || func == 4'h9
            || func == 4'hc || func == 4'hd || func == 4'he) && !parallel
           ? ext_clk : 1'b1;
    pre_zero = (s_r.prescale == 8'h00);
    cnt_en = run & tick & pre_zero;
    cmp0_hit = cnt_en && (s_r.count == s_r.cmp0);
    cmp1_hit = cnt_en && (s_r.count == s_r.cmp1);
    wrap = cnt_en && (up ? (s_r.count == 16'hffff) : (s_r.count == 16'h0000));
    // trigger acts whatever the run enable
    cap0 = trig && (mode == MFT_CAP0_MON1 || mode == MFT_CAP_BOTH);
    cap1 = trig && (mode == MFT_LOAD0_CAP1 || mode == MFT_CAP_BOTH);
    clr = (s_r.counter_control[`MFT_CC_CLR_CAP] & (cap0 | cap1))
          | (s_r.counter_control[`MFT_CC_CLR_CMP] & cmp0_hit)
          | (bus.wr && bus.addr == `MFT_OFS_COUNTER_CONTROL && bus.wdata[`MFT_CC_CLEAR]);
    reload = (trig && !cap0) || (wrap && !s_r.operating_mode_select[`MFT_OM_ONESHOT]);
    hits = {wrap, cmp1_hit, cmp0_hit};
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sync_a = {s_r.sync_a[1:0], pins.in_a};
    s_nxt.sync_b = {s_r.sync_b[1:0], pins.in_b};
    s_nxt.in_a = a_lvl;
    s_nxt.in_b = b_lvl;
    // Kept so latched pin directions survive between events
    s_nxt.dir_up = up;
    // preset taken at underflow or reload; divide by value plus one
    if (run && tick)
    begin
      s_nxt.prescale = pre_zero ? s_r.prescale_preset : s_r.prescale - 8'h01;
    end
    if (clr || reload)
    begin
      s_nxt.prescale = s_r.prescale_preset;
    end
    if (cnt_en)
    begin
      s_nxt.count = up ? s_r.count + 16'h0001 : s_r.count - 16'h0001;
    end
    if (wrap)
    begin
      s_nxt.wrap_seen = 1'b1;
      if (s_r.operating_mode_select[`MFT_OM_ONESHOT])
      begin
        s_nxt.armed = 1'b1;
      end
      else
      begin
        s_nxt.count = s_r.reg0;
      end
    end
    // retrigger allowed when bit is zero or the one-shot bit is set
    if (trig && !cap0 && (!s_r.armed || !s_r.operating_mode_select[`MFT_OM_NORETRIG]
        || s_r.operating_mode_select[`MFT_OM_ONESHOT]))
    begin
      s_nxt.count = s_r.reg0;
      s_nxt.armed = 1'b0;
    end
    if (cap0)
    begin
      s_nxt.reg0 = s_r.count;
      s_nxt.capture_wrap = s_r.wrap_seen | wrap;
      s_nxt.wrap_seen = 1'b0;
    end
    if (cap1)
    begin
      s_nxt.reg1 = s_r.count;
    end
    if (clr)
    begin
      s_nxt.count = 16'h0000;
    end
    // output A actions; coinciding codes ANDed
    s_nxt.out_a = apply_action(merge_actions({
                  s_r.output_a_actions[`MFT_OA_WRAP_HI -: 2],
                  s_r.output_a_actions[`MFT_OA_CMP1_HI -: 2],
                  s_r.output_a_actions[`MFT_OA_CMP0_HI -: 2]}, hits), s_r.out_a);
    // output B actions; same encoding and AND
    s_nxt.out_b = apply_action(merge_actions({
                  s_r.output_b_actions[`MFT_OA_WRAP_HI -: 2],
                  s_r.output_b_actions[`MFT_OA_CMP1_HI -: 2],
                  s_r.output_b_actions[`MFT_OA_CMP0_HI -: 2]}, hits), s_r.out_b);
    s_nxt.chip_event = cmp0_hit & s_r.output_a_actions[`MFT_OA_EVENT];
    // Register writes
    if (bus.wr)
    begin
      case (bus.addr)
        `MFT_OFS_COUNTER_CONTROL: s_nxt.counter_control = {bus.wdata[7:5], 1'b0,
                                                         bus.wdata[3], 3'b000};
        `MFT_OFS_OPERATING_MODE: s_nxt.operating_mode_select = bus.wdata;
        `MFT_OFS_INPUT_PIN_SETUP: s_nxt.input_pin_setup = bus.wdata;
        `MFT_OFS_PRESCALE_PRESET: s_nxt.prescale_preset = bus.wdata;
        `MFT_OFS_OUTPUT_A_ACTIONS:
        begin
          s_nxt.output_a_actions = bus.wdata;
          s_nxt.out_a = bus.wdata[`MFT_OA_PRESET];
        end
        `MFT_OFS_OUTPUT_B_ACTIONS:
        begin
          s_nxt.output_b_actions = bus.wdata;
          s_nxt.out_b = bus.wdata[`MFT_OA_PRESET];
        end
        `MFT_OFS_CMP0_LO, `MFT_OFS_CMP0_HI:
          s_nxt.cmp0 = wr_half(s_r.cmp0, bus.addr[0], bus.wdata);
        `MFT_OFS_CMP1_LO, `MFT_OFS_CMP1_HI:
          s_nxt.cmp1 = wr_half(s_r.cmp1, bus.addr[0], bus.wdata);
        `MFT_OFS_REG0_LO, `MFT_OFS_REG0_HI:
          s_nxt.reg0 = wr_half(s_r.reg0, bus.addr[0], bus.wdata);
        `MFT_OFS_REG1_LO, `MFT_OFS_REG1_HI:
          s_nxt.reg1 = wr_half(s_r.reg1, bus.addr[0], bus.wdata);
        default: s_nxt.rdata = s_nxt.rdata;
      endcase
    end
    // Reads; unmapped addresses return zero
    s_nxt.rdata = 8'h00;
    if (bus.rd)
    begin
      case (bus.addr)
        `MFT_OFS_COUNTER_CONTROL: s_nxt.rdata = {s_r.counter_control[7:5], 1'b0,
                                               s_r.counter_control[3], up,
                                               s_r.capture_wrap, run};
        `MFT_OFS_OPERATING_MODE: s_nxt.rdata = s_r.operating_mode_select;
        `MFT_OFS_INPUT_PIN_SETUP: s_nxt.rdata = s_r.input_pin_setup;
        `MFT_OFS_PRESCALE_PRESET: s_nxt.rdata = s_r.prescale_preset;
        `MFT_OFS_OUTPUT_A_ACTIONS: s_nxt.rdata = {s_r.output_a_actions[7:1], output_a};
        `MFT_OFS_OUTPUT_B_ACTIONS: s_nxt.rdata = {s_r.output_b_actions[7:1], output_b};
        `MFT_OFS_COUNT_LO: s_nxt.rdata = s_r.count[7:0];
        `MFT_OFS_COUNT_HI: s_nxt.rdata = s_r.count[15:8];
        `MFT_OFS_CMP0_LO: s_nxt.rdata = s_r.cmp0[7:0];
        `MFT_OFS_CMP0_HI: s_nxt.rdata = s_r.cmp0[15:8];
        `MFT_OFS_CMP1_LO: s_nxt.rdata = s_r.cmp1[7:0];
        `MFT_OFS_CMP1_HI: s_nxt.rdata = s_r.cmp1[15:8];
        `MFT_OFS_REG0_LO: s_nxt.rdata = s_r.reg0[7:0];
        `MFT_OFS_REG0_HI: s_nxt.rdata = s_r.reg0[15:8];
        `MFT_OFS_REG1_LO: s_nxt.rdata = s_r.reg1[7:0];
        `MFT_OFS_REG1_HI: s_nxt.rdata = s_r.reg1[15:8];
        default: s_nxt.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // disabled outputs forced high
  assign output_a = s_r.operating_mode_select[`MFT_OM_OEA] ? s_r.out_a : 1'b1;
  assign output_b = s_r.operating_mode_select[`MFT_OM_OEB] ? s_r.out_b : 1'b1;
  assign compare0_chip_event = s_r.chip_event;
  assign rdata = s_r.rdata;
  assign count = s_r.count;
endmodule // mft_ctrl

// *** verif/mft_ctrl_assertions.sv ***
// Port-level checks of the timer control block.
// Assumes the package is compiled first; bound to every mft_ctrl.
`timescale 1ns/1ps
module mft_ctrl_assertions
  import mft_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire mft_ctrl_pkg::mft_bus_req_t bus,
  input wire logic [7:0] rdata,
  input wire mft_ctrl_pkg::mft_pins_t pins,
  input wire logic output_a,
  input wire logic output_b,
  input wire logic compare0_chip_event,
  input wire logic [15:0] count
);
  logic [7:0] cc_r;
  logic [7:0] md_r;
  logic [7:0] ip_r;
  logic [7:0] oa_r;
  logic dir_fixed;
  logic trig_fn;
  // ==========================================================
  // Shadow copies of written registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cc_r <= 8'h00;
      md_r <= 8'h00;
      ip_r <= 8'h00;
      oa_r <= 8'h00;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        8'hf8: cc_r <= bus.wdata;
        8'hf9: md_r <= bus.wdata;
        8'hfa: ip_r <= bus.wdata;
        8'hfc: oa_r <= bus.wdata;
        default: ;
      endcase
    end
  end
  // Triggers may load the count even while stopped
  assign trig_fn = ip_r[7:4] inside {4'h1, 4'h3, 4'h5, 4'h7, 4'ha, 4'hd, 4'he, 4'hf};
  assign dir_fixed = ip_r[7:4] inside {[4'h8:4'hc]};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // Properties
  clear_reads_zero_a: assert property (bus.rd && bus.addr == 8'hf8 |=> !rdata[4])
    else $error("clear strobe read back as one");
  clear_zeroes_count_a: assert property (bus.wr && bus.addr == 8'hf8 && bus.wdata[4]
    |=> count == 16'h0000)
    else $error("count not cleared by strobe");
  outa_forced_high_a: assert property (!md_r[6] |-> output_a)
    else $error("disabled output a not high");
  outb_forced_high_a: assert property (!md_r[7] |-> output_b)
    else $error("disabled output b not high");
  event_one_cycle_a: assert property (compare0_chip_event |=> !compare0_chip_event)
    else $error("chip event longer than one cycle");
  event_needs_enable_a: assert property (compare0_chip_event |-> oa_r[1] || $past(oa_r[1]))
    else $error("chip event while disabled");
  count_frozen_a: assert property (!pins.global_count_enable
    && !$past(pins.global_count_enable) && !$past(bus.wr) && !trig_fn |-> $stable(count))
    else $error("count moved without global enable");
  run_status_a: assert property (bus.rd && bus.addr == 8'hf8 |=>
    rdata[7] == $past(cc_r[7]) && (!rdata[0] || rdata[7]))
    else $error("run bit or running status wrong");
  direction_status_a: assert property (bus.rd && bus.addr == 8'hf8 && !dir_fixed |=>
    rdata[2] == $past(cc_r[3]))
    else $error("direction status not software direction");
  mode_readback_a: assert property (bus.rd && bus.addr == 8'hf9 |=> rdata == $past(md_r))
    else $error("mode register read back wrong");
  preset_level_a: assert property (bus.wr && bus.addr == 8'hfc |=>
    output_a == $past(bus.wdata[0]) || !md_r[6])
    else $error("output a not at preset level");
endmodule // mft_ctrl_assertions
bind mft_ctrl mft_ctrl_assertions mft_ctrl_assertions_i (
  .clk(clk),
  .arst_n(arst_n),
  .bus(bus),
  .rdata(rdata),
  .pins(pins),
  .output_a(output_a),
  .output_b(output_b),
  .compare0_chip_event(compare0_chip_event),
  .count(count)
);

// *** verif/mft_pin_model.sv ***
// Outside signal source on the two timer input pins.
// Assumes the timer filters pins over three clocks.
`timescale 1ns/1ps
module mft_pin_model (
  input wire logic clk,
  output logic in_a,
  output logic in_b
);
  initial
  begin
    in_a = 1'b0;
    in_b = 1'b0;
  end
  // Four clocks per level, well above the filter width
  task automatic pulse_b(input int n);
    for (int i = 0; i < n; i++)
    begin
      in_b <= 1'b1;
      in_a <= ~in_a;
      repeat (4) @(posedge clk);
      in_b <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask
endmodule // mft_pin_model

// *** verif/tb_mft_ctrl.sv ***
// Self-checking bench of the timer control block.
// Assumes the package, the checker and the pin model are compiled first.
`timescale 1ns/1ps
module tb_mft_ctrl;
  import mft_ctrl_pkg::*;
  logic clk;
  logic arst_n;
  logic gce;
  mft_bus_req_t bus;
  mft_pins_t pins;
  logic [7:0] rdata;
  logic output_a;
  logic output_b;
  logic compare0_chip_event;
  logic [15:0] count;
  logic pin_a;
  logic pin_b;
  int n_fail;
  int n_tests;
  int n_event;
  assign pins = {pin_a, pin_b, gce};
  mft_ctrl mft_ctrl_i (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata), .pins(pins),
    .output_a(output_a), .output_b(output_b), .compare0_chip_event(compare0_chip_event),
    .count(count));
  mft_pin_model pin_i (.clk(clk), .in_a(pin_a), .in_b(pin_b));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (compare0_chip_event === 1'b1)
      n_event++;
  end
  // ==========================================================
  // Bus and compare tasks
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk({10'h000, rdata & m}, {10'h000, e});
    @(posedge clk);
  endtask
  // Outputs and count, masked, after edge updates land
  task automatic ochk(input logic [17:0] e, input logic [17:0] m);
    @(posedge clk);
    #1;
    chk({output_b, output_a, count} & m, e);
    @(posedge clk);
  endtask
  task automatic final_report();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    n_fail = 0;
    n_tests = 0;
    n_event = 0;
    bus = '0;
    gce = 1'b1;
    arst_n = 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    // Preset bits read the pin, so masked here
    for (int a = 8'hf8; a <= 8'hfd; a++)
      rchk(a[7:0], 8'h00, (a >= 8'hfc) ? 8'hfe : 8'hff);
    rchk(8'h10, 8'h00, 8'hff);
    ochk({2'b11, 16'h0000}, 18'h3ffff);
    for (int m = 0; m < 8; m++)
    begin
      wr(8'hf9, {2'b00, m[2:0], 3'b011});
      rchk(8'hf9, {2'b00, m[2:0], 3'b011}, 8'hff);
    end
    wr(8'hfa, 8'ha5);
    rchk(8'hfa, 8'ha5, 8'hff);
    wr(8'hfb, 8'h18);
    rchk(8'hfb, 8'h18, 8'hff);
    wr(8'hfb, 8'h00);
    // Pin b as external clock on rising edges
    wr(8'hf9, 8'hc0);
    wr(8'hfa, 8'h42);
    wr(8'hf8, 8'h88);
    pin_i.pulse_b(3);
    ochk(18'h00003, 18'h0ffff);
    rchk(8'hf8, 8'h8d, 8'hff);
    gce <= 1'b0;
    pin_i.pulse_b(2);
    ochk(18'h00003, 18'h0ffff);
    gce <= 1'b1;
    wr(8'hf8, 8'h08);
    pin_i.pulse_b(2);
    ochk(18'h00003, 18'h0ffff);
    rchk(8'hf8, 8'h0c, 8'hff);
    wr(8'hf8, 8'h80);
    pin_i.pulse_b(1);
    ochk(18'h00002, 18'h0ffff);
    wr(8'hf8, 8'h90);
    ochk(18'h00000, 18'h0ffff);
    rchk(8'hf8, 8'h81, 8'hff);
    // Reset and toggle together merge to set
    wr(8'hf2, 8'h02);
    wr(8'hf3, 8'h00);
    wr(8'hf4, 8'h02);
    wr(8'hf5, 8'h00);
    wr(8'hfc, 8'h9e);
    wr(8'hfd, 8'h7c);
    ochk(18'h00000, 18'h30000);
    n_event = 0;
    wr(8'hf8, 8'ha8);
    pin_i.pulse_b(3);
    ochk({2'b11, 16'h0000}, 18'h3ffff);
    chk(n_event[17:0], 18'h00001);
    rchk(8'hfc, 8'h9f, 8'hff);
    // New preset lands at the next underflow or clear
    wr(8'hf8, 8'h88);
    wr(8'hfb, 8'h01);
    pin_i.pulse_b(1);
    wr(8'hf8, 8'h98);
    pin_i.pulse_b(4);
    ochk(18'h00002, 18'h0ffff);
    // Stopped trigger under bivalue captures both registers and clears
    wr(8'hf8, 8'h40);
    wr(8'hfa, 8'h12);
    wr(8'hf9, 8'he8);
    pin_i.pulse_b(1);
    rchk(8'hf6, 8'h02, 8'hff);
    rchk(8'hee, 8'h02, 8'hff);
    ochk(18'h00000, 18'h0ffff);
    final_report();
  end
endmodule // tb_mft_ctrl
